// ==== inc/ucfr_pkg.sv ====
// Constants and types for the undercurrent fault response sequencer
package ucfr_pkg;

  // Command code of the response byte
  localparam logic [7:0] CMD_UC_RESPONSE = 8'h00E6;

  // Field positions of the response byte
  localparam int RESP_MODE_HI  = 7;
  localparam int RESP_MODE_LO  = 6;
  localparam int RESP_RETRY_HI = 5;
  localparam int RESP_RETRY_LO = 3;
  localparam int RESP_UNITS_HI = 2;
  localparam int RESP_UNITS_LO = 0;

  // Reset value of the response byte
  localparam logic [7:0] RESP_RESET = 8'h0000;

  // Response codes
  localparam logic [1:0] MODE_IGNORE   = 2'h0;
  localparam logic [1:0] MODE_CONTINUE = 2'h1;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h2;
  localparam logic [1:0] MODE_HOLD     = 2'h3;

  // Retry codes
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Timing
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int CONT_UNIT_US    = 10000;
  localparam int RETRY_UNIT_US   = 8200;
  localparam int PS_PER_US       = 1000000;
  localparam int CONT_UNIT_CYC   = CONT_UNIT_US * (PS_PER_US / CLK_PERIOD_PS);
  localparam int RETRY_UNIT_CYC  = RETRY_UNIT_US * (PS_PER_US / CLK_PERIOD_PS);
  localparam int UNIT_CNT_W      = 21;

  // Sequencer states, Gray coded along the delay and retry path
  typedef enum logic [2:0] {
    ST_RUN      = 3'h0,
    ST_DELAY    = 3'h1,
    ST_OFF_WAIT = 3'h3,
    ST_RESTART  = 3'h2,
    ST_LATCHED  = 3'h6,
    ST_HOLD     = 3'h7
  } ucfr_state_t;

endpackage : ucfr_pkg

// ==== rtl/ucfr_timer.sv ====
// Delay timer counting whole units of a programmable cycle length
`timescale 1ns/10ps
module ucfr_timer (
  // Clock and reset
  input  wire logic                             clk,
  input  wire logic                             nrst,
  input  wire logic                             ce,
  // Control
  input  wire logic                             start,
  input  wire logic                             abort,
  input  wire logic [2:0]                       units,
  input  wire logic [ucfr_pkg::UNIT_CNT_W-1:0]  unit_cyc,
  // Status
  output logic                                  done
);

  logic                            busy_reg;
  logic                            busy_next;
  logic [ucfr_pkg::UNIT_CNT_W-1:0] cyc_reg;
  logic [ucfr_pkg::UNIT_CNT_W-1:0] cyc_next;
  logic [2:0]                      unit_reg;
  logic [2:0]                      unit_next;
  logic                            done_reg;
  logic                            done_next;

  always_comb
  begin
    busy_next = busy_reg;
    cyc_next  = cyc_reg;
    unit_next = unit_reg;
    done_next = 1'b0;
    if (abort)
    begin
      busy_next = 1'b0;
    end
    else if (start)
    begin
      busy_next = 1'b1;
      cyc_next  = '0;
      unit_next = units;
    end
    else if (busy_reg)
    begin
      if (unit_reg == 3'h0)
      begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
      else if (cyc_reg == unit_cyc - 1'b1)
      begin
        cyc_next  = '0;
        unit_next = unit_reg - 3'h1;
      end
      else
      begin
        cyc_next = cyc_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_reg <= 1'b0;
      cyc_reg  <= '0;
      unit_reg <= 3'h0;
      done_reg <= 1'b0;
    end
    else if (ce)
    begin
      busy_reg <= busy_next;
      cyc_reg  <= cyc_next;
      unit_reg <= unit_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;

endmodule : ucfr_timer

// ==== rtl/ucfr_core.sv ====
// Undercurrent fault response sequencer with its command byte
//
// Summary of operation
// RULE1: Bits 7:6 pick response; always alert and status
// RULE2: Code 00 flags fault, output keeps running
// RULE3: Code 01 runs for delay, then retry
// RULE4: Code 10 shuts output at once, then retry
// RULE5: Code 11 holds output off while fault persists
// RULE6: Bits 5:3 set number of restart attempts
// RULE7: Retry 000 stays off until fault cleared
// RULE8: Retry 111 retries until disabled or other fault
// RULE9: Bits 2:0 units, 10 ms for continue delay
// RULE10: Same units are 8.2 ms between restarts
// RULE11: Layout standard, sets the undercurrent status bit
// RULE12: Whole byte read and written at code E6
// RULE13: Retry 001..110 tries that often, then stays off
// RULE14: Clear or rewrite resets attempts and timer
// RULE15: Fault input taken synchronous on the clock
`timescale 1ns/10ps
module ucfr_core #(
  parameter logic [ucfr_pkg::UNIT_CNT_W-1:0] CONT_UNIT_CYC =
    ucfr_pkg::UNIT_CNT_W'(ucfr_pkg::CONT_UNIT_CYC),
  parameter logic [ucfr_pkg::UNIT_CNT_W-1:0] RETRY_UNIT_CYC =
    ucfr_pkg::UNIT_CNT_W'(ucfr_pkg::RETRY_UNIT_CYC)
) (
  // Clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  // Command port
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic        CMD_WR,
  input  wire logic        CMD_RD,
  input  wire logic [7:0]  CMD_WDATA,
  output logic      [7:0]  CMD_RDATA,
  output logic             CMD_ACK,
  // Fault and system inputs
  input  wire logic        UC_FAULT,
  input  wire logic        CLEAR_FAULTS,
  input  wire logic        OUTPUT_EN_REQ,
  input  wire logic        OTHER_FAULT_SHDN,
  // Outputs
  output logic             OUTPUT_ENABLE,
  output logic             UC_STATUS,
  output logic             ALERT_LINE_N,
  output logic      [2:0]  ATTEMPT_COUNT,
  output logic      [2:0]  SEQ_STATE
);

  // Decode of the command code
  function automatic logic cmd_hit(input logic [7:0] code);
    cmd_hit = (code == ucfr_pkg::CMD_UC_RESPONSE);
  endfunction : cmd_hit

  // Command register group
  logic [7:0] resp_reg;
  logic [7:0] resp_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       ack_reg;
  logic       ack_next;
  logic       cfg_write;

  // Field views
  logic [1:0] mode;
  logic [2:0] retry;
  logic [2:0] units;

  // Sequencer group
  ucfr_pkg::ucfr_state_t state_reg;
  ucfr_pkg::ucfr_state_t state_next;
  logic [2:0]            attempt_reg;
  logic [2:0]            attempt_next;
  logic                  status_reg;
  logic                  status_next;
  logic                  alert_n_reg;
  logic                  alert_n_next;
  logic                  out_en_reg;
  logic                  out_en_next;

  // Timer control
  logic                                  tmr_start;
  logic                                  tmr_abort;
  logic                                  tmr_done;
  logic [ucfr_pkg::UNIT_CNT_W-1:0]       tmr_unit;
  logic                                  reset_seq;
  logic                                  stop_retry;

  assign cfg_write = CMD_WR && cmd_hit(CMD_CODE);

  assign mode  = resp_reg[ucfr_pkg::RESP_MODE_HI:ucfr_pkg::RESP_MODE_LO];
  assign retry = resp_reg[ucfr_pkg::RESP_RETRY_HI:ucfr_pkg::RESP_RETRY_LO];
  assign units = resp_reg[ucfr_pkg::RESP_UNITS_HI:ucfr_pkg::RESP_UNITS_LO];

  // Command port: full byte stored and returned
  always_comb
  begin
    resp_next  = resp_reg;
    rdata_next = rdata_reg;
    ack_next   = 1'b0;
    if (cfg_write)
    begin
      resp_next = CMD_WDATA; // RULE12
      ack_next  = 1'b1;
    end
    else if (CMD_RD && cmd_hit(CMD_CODE))
    begin
      rdata_next = resp_reg; // RULE12
      ack_next   = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      resp_reg  <= ucfr_pkg::RESP_RESET;
      rdata_reg <= 8'h0000;
      ack_reg   <= 1'b0;
    end
    else if (CE)
    begin
      resp_reg  <= resp_next;
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
    end
  end

  // Restart and abort conditions
  assign reset_seq  = CLEAR_FAULTS || cfg_write; // RULE14
  assign stop_retry = !OUTPUT_EN_REQ || OTHER_FAULT_SHDN; // RULE8

  // Sequencer: next state, attempts, timer requests
  always_comb
  begin
    state_next   = state_reg;
    attempt_next = attempt_reg;
    tmr_start    = 1'b0;
    tmr_abort    = 1'b0;
    tmr_unit     = RETRY_UNIT_CYC; // RULE10
    if (reset_seq)
    begin
      state_next   = ucfr_pkg::ST_RUN; // RULE14
      attempt_next = 3'h0;
      tmr_abort    = 1'b1;
    end
    else
    begin
      case (state_reg)
        ucfr_pkg::ST_RUN:
        begin
          attempt_next = 3'h0;
          if (UC_FAULT && OUTPUT_EN_REQ && !OTHER_FAULT_SHDN) // RULE15
          begin
            case (mode) // RULE1
              ucfr_pkg::MODE_IGNORE:
              begin
                state_next = ucfr_pkg::ST_RUN; // RULE2
              end
              ucfr_pkg::MODE_CONTINUE:
              begin
                state_next = ucfr_pkg::ST_DELAY; // RULE3
                tmr_start  = 1'b1;
                tmr_unit   = CONT_UNIT_CYC; // RULE9
              end
              ucfr_pkg::MODE_SHUTDOWN:
              begin
                if (retry == ucfr_pkg::RETRY_NONE)
                begin
                  state_next = ucfr_pkg::ST_LATCHED; // RULE7
                end
                else
                begin
                  state_next = ucfr_pkg::ST_OFF_WAIT; // RULE4
                  tmr_start  = 1'b1;
                end
              end
              ucfr_pkg::MODE_HOLD:
              begin
                state_next = ucfr_pkg::ST_HOLD; // RULE5
              end
              default:
              begin
                state_next = ucfr_pkg::ST_RUN;
              end
            endcase
          end
        end
        ucfr_pkg::ST_DELAY:
        begin
          tmr_unit = CONT_UNIT_CYC; // RULE9
          if (stop_retry)
          begin
            state_next = ucfr_pkg::ST_RUN;
            tmr_abort  = 1'b1;
          end
          else if (tmr_done)
          begin
            if (!UC_FAULT)
            begin
              state_next = ucfr_pkg::ST_RUN;
            end
            else if (retry == ucfr_pkg::RETRY_NONE)
            begin
              state_next = ucfr_pkg::ST_LATCHED; // RULE3
            end
            else
            begin
              state_next = ucfr_pkg::ST_OFF_WAIT; // RULE3
              tmr_start  = 1'b1;
            end
          end
        end
        ucfr_pkg::ST_OFF_WAIT:
        begin
          if (stop_retry)
          begin
            state_next = ucfr_pkg::ST_RUN; // RULE8
            tmr_abort  = 1'b1;
          end
          else if (tmr_done)
          begin
            state_next   = ucfr_pkg::ST_RESTART; // RULE6
            attempt_next = attempt_reg + 3'h1;
            tmr_start    = 1'b1; // RULE10
          end
        end
        ucfr_pkg::ST_RESTART:
        begin
          if (stop_retry)
          begin
            state_next = ucfr_pkg::ST_RUN; // RULE8
            tmr_abort  = 1'b1;
          end
          else if (UC_FAULT)
          begin
            if (retry != ucfr_pkg::RETRY_FOREVER && attempt_reg >= retry)
            begin
              state_next = ucfr_pkg::ST_LATCHED; // RULE13
              tmr_abort  = 1'b1;
            end
            else
            begin
              state_next = ucfr_pkg::ST_OFF_WAIT; // RULE8
            end
          end
          else if (tmr_done)
          begin
            state_next   = ucfr_pkg::ST_RUN;
            attempt_next = 3'h0;
          end
        end
        ucfr_pkg::ST_LATCHED:
        begin
          state_next = ucfr_pkg::ST_LATCHED; // RULE7
        end
        ucfr_pkg::ST_HOLD:
        begin
          if (!UC_FAULT)
          begin
            state_next = ucfr_pkg::ST_RUN; // RULE5
          end
        end
        default:
        begin
          state_next = ucfr_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Status and alert latch on the fault input until CLEAR_FAULTS, output enable follows the next state
  always_comb
  begin
    status_next = status_reg;
    if (CLEAR_FAULTS)
    begin
      status_next = 1'b0;
    end
    if (UC_FAULT)
    begin
      status_next = 1'b1; // RULE11
    end
    alert_n_next = !status_next; // RULE1
    case (state_next)
      ucfr_pkg::ST_RUN,
      ucfr_pkg::ST_DELAY,
      ucfr_pkg::ST_RESTART:
      begin
        out_en_next = OUTPUT_EN_REQ; // RULE2
      end
      default:
      begin
        out_en_next = 1'b0; // RULE4
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_reg   <= ucfr_pkg::ST_RUN;
      attempt_reg <= 3'h0;
      status_reg  <= 1'b0;
      alert_n_reg <= 1'b1;
      out_en_reg  <= 1'b0;
    end
    else if (CE)
    begin
      state_reg   <= state_next;
      attempt_reg <= attempt_next;
      status_reg  <= status_next;
      alert_n_reg <= alert_n_next;
      out_en_reg  <= out_en_next;
    end
  end

  // Delay and retry interval timer
  ucfr_timer u_timer (
    .clk      (CLK),
    .nrst     (NRST),
    .ce       (CE),
    .start    (tmr_start),
    .abort    (tmr_abort),
    .units    (units),
    .unit_cyc (tmr_unit),
    .done     (tmr_done)
  );

  // Outputs
  assign CMD_RDATA     = rdata_reg;
  assign CMD_ACK       = ack_reg;
  assign OUTPUT_ENABLE = out_en_reg;
  assign UC_STATUS     = status_reg;
  assign ALERT_LINE_N  = alert_n_reg;
  assign ATTEMPT_COUNT = attempt_reg;
  assign SEQ_STATE     = state_reg;

endmodule : ucfr_core

// ==== tb/ucfr_core_sva.sv ====
// Checker for the undercurrent fault response sequencer
`timescale 1ns/10ps
module ucfr_core_sva (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       NRST,
  input wire logic       CE,
  // Command port
  input wire logic [7:0] CMD_CODE,
  input wire logic       CMD_WR,
  input wire logic       CMD_RD,
  input wire logic [7:0] CMD_WDATA,
  input wire logic       CMD_ACK,
  // Sequencer
  input wire logic       UC_FAULT,
  input wire logic       CLEAR_FAULTS,
  input wire logic       OUTPUT_EN_REQ,
  input wire logic       OTHER_FAULT_SHDN,
  input wire logic       OUTPUT_ENABLE,
  input wire logic       UC_STATUS,
  input wire logic       ALERT_LINE_N,
  input wire logic [2:0] ATTEMPT_COUNT,
  input wire logic [2:0] SEQ_STATE
);
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic       hit;
  logic       react;
  assign hit = CE && CMD_CODE == ucfr_pkg::CMD_UC_RESPONSE;
  assign react = CE && UC_FAULT && OUTPUT_EN_REQ && SEQ_STATE == 3'h0
    && !CMD_WR && !CLEAR_FAULTS && !OTHER_FAULT_SHDN;
  // Shadow of the response byte
  always_comb
  begin
    cfg_next = cfg_reg;
    if (hit && CMD_WR)
    begin
      cfg_next = CMD_WDATA;
    end
  end
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cfg_reg <= ucfr_pkg::RESP_RESET;
    end
    else
    begin
      cfg_reg <= cfg_next;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_ack_hit: assert property (hit && (CMD_WR || CMD_RD) |=> CMD_ACK)
    else $error("no ack after hit");
  a_flag_set: assert property (CE && UC_FAULT |=> UC_STATUS)
    else $error("status not set");
  a_alert_low: assert property (UC_STATUS |-> !ALERT_LINE_N)
    else $error("alert not low");
  a_mode_ignore: assert property (react && cfg_reg[7:6] == 2'h0
    |=> SEQ_STATE == 3'h0 && OUTPUT_ENABLE) else $error("ignore broken");
  a_shut_now: assert property (react && cfg_reg[7:6] == 2'h2
    |=> !OUTPUT_ENABLE) else $error("no shutdown");
  a_hold_off: assert property (react && cfg_reg[7:6] == 2'h3
    |=> SEQ_STATE == 3'h7 && !OUTPUT_ENABLE) else $error("no hold");
  a_latch_stay: assert property (CE && SEQ_STATE == 3'h6
    && !CLEAR_FAULTS && !CMD_WR |=> SEQ_STATE == 3'h6 && !OUTPUT_ENABLE)
    else $error("latch left");
  a_attempt_cap: assert property (cfg_reg[5:3] != 3'h7
    |-> ATTEMPT_COUNT <= cfg_reg[5:3]) else $error("too many tries");
  a_clear_run: assert property (CE && CLEAR_FAULTS
    |=> SEQ_STATE == 3'h0 && ATTEMPT_COUNT == 3'h0)
    else $error("clear ignored");
  c_latched: cover property (SEQ_STATE == 3'h6);
  c_hold: cover property (SEQ_STATE == 3'h7);
  c_two_tries: cover property (ATTEMPT_COUNT == 3'h2);
endmodule : ucfr_core_sva

// ==== tb/ucfr_host.sv ====
// Host model driving the command port
`timescale 1ns/10ps
module ucfr_host (
  // Clock
  input wire logic       clk,
  // Command port
  output logic     [7:0] cmd_code,
  output logic           cmd_wr,
  output logic           cmd_rd,
  output logic     [7:0] cmd_wdata,
  input wire logic [7:0] cmd_rdata,
  input wire logic       cmd_ack
);
  initial
  begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 8'hA5;
  end
  // One byte access, answer taken one edge after the strobe
  task automatic xfer(input logic wr, input logic [7:0] code,
    input logic [7:0] wd, output logic [7:0] rd, output logic ack);
    @(posedge clk);
    #1;
    cmd_code = code;
    cmd_wr = wr;
    cmd_rd = !wr;
    cmd_wdata = wd;
    @(posedge clk);
    #1;
    ack = cmd_ack;
    rd = cmd_rdata;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = ~wd;
    cmd_code = ~code;
  endtask : xfer
endmodule : ucfr_host

// ==== tb/tb.sv ====
// Self-checking bench for the undercurrent fault response sequencer
`timescale 1ns/10ps
module tb;
  logic [7:0]  code;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  rv;
  logic [2:0]  attempts;
  logic [2:0]  state;
  logic [11:0] rows [5];
  logic        clk;
  logic        nrst;
  logic        ce;
  logic        wr;
  logic        rd;
  logic        ack;
  logic        av;
  logic        fault;
  logic        clr;
  logic        en_req;
  logic        shdn;
  logic        oe;
  logic        status;
  logic        alert_n;
  int          n;
  int          fails;
  int          n_checks;
  ucfr_core #(.CONT_UNIT_CYC(21'h14), .RETRY_UNIT_CYC(21'h10)) dut_u (
    .CLK(clk), .NRST(nrst), .CE(ce), .CMD_CODE(code), .CMD_WR(wr),
    .CMD_RD(rd), .CMD_WDATA(wdata), .CMD_RDATA(rdata), .CMD_ACK(ack),
    .UC_FAULT(fault), .CLEAR_FAULTS(clr), .OUTPUT_EN_REQ(en_req),
    .OTHER_FAULT_SHDN(shdn), .OUTPUT_ENABLE(oe), .UC_STATUS(status),
    .ALERT_LINE_N(alert_n), .ATTEMPT_COUNT(attempts), .SEQ_STATE(state));
  ucfr_host host_u (.clk(clk), .cmd_code(code), .cmd_wr(wr), .cmd_rd(rd),
    .cmd_wdata(wdata), .cmd_rdata(rdata), .cmd_ack(ack));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_st(input logic [2:0] s);
    n = 0;
    while (state !== s && n < 300)
    begin
      tick();
      n++;
    end
    if (n == 300)
    begin
      fails++;
      stop_test();
    end
  endtask : wait_st
  task automatic put(input logic [7:0] b);
    host_u.xfer(1'b1, ucfr_pkg::CMD_UC_RESPONSE, b, rv, av);
    chk(8'(av), 8'h01);
  endtask : put
  task automatic clear_uc();
    fault = 1'b0;
    clr = 1'b1;
    tick();
    clr = 1'b0;
    tick();
  endtask : clear_uc
  initial
  begin
    rows = '{{8'h00, 3'h0, 1'b1}, {8'h40, 3'h1, 1'b1},
      {8'h80, 3'h6, 1'b0}, {8'h88, 3'h3, 1'b0}, {8'hC0, 3'h7, 1'b0}};
    fails = 0;
    n_checks = 0;
    {fault, clr, shdn, nrst} = 4'h0;
    en_req = 1'b1;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk({status, alert_n, state, attempts}, 8'h40);
    chk(8'(oe), 8'h00);
    host_u.xfer(1'b0, ucfr_pkg::CMD_UC_RESPONSE, 8'h00, rv, av);
    chk(rv, ucfr_pkg::RESP_RESET);
    chk(8'(av), 8'h01);
    host_u.xfer(1'b1, 8'hE7, 8'h55, rv, av);
    chk(8'(av), 8'h00);
    host_u.xfer(1'b0, ucfr_pkg::CMD_UC_RESPONSE, 8'h00, rv, av);
    chk(rv, ucfr_pkg::RESP_RESET);
    chk(8'(oe), 8'h01);
    $display("reset test done");
    for (int i = 0; i < 5; i++)
    begin
      put(rows[i][11:4]);
      host_u.xfer(1'b0, ucfr_pkg::CMD_UC_RESPONSE, 8'h00, rv, av);
      chk(rv, rows[i][11:4]);
      fault = 1'b1;
      tick();
      chk(8'({state, oe}), 8'(rows[i][3:0]));
      chk(8'({status, alert_n}), 8'h02);
      clear_uc();
      chk(8'({status, state}), 8'h00);
    end
    $display("mode table done");
    put(8'h91);
    fault = 1'b1;
    tick();
    wait_st(3'h2);
    chk(8'(n >= 15 && n <= 19), 8'h01);
    chk(8'({oe, attempts}), 8'h09);
    wait_st(3'h6);
    chk(8'({oe, attempts}), 8'h02);
    repeat (30) tick();
    chk(8'(state), 8'h06);
    put(8'h91);
    chk(8'({state, attempts}), 8'h00);
    tick();
    nrst = 1'b0;
    tick();
    chk({status, alert_n, state, attempts}, 8'h40);
    chk(8'({oe, ack}), 8'h00);
    nrst = 1'b1;
    tick();
    chk(8'({oe, state}), 8'h08);
    host_u.xfer(1'b0, ucfr_pkg::CMD_UC_RESPONSE, 8'h00, rv, av);
    chk(rv, ucfr_pkg::RESP_RESET);
    clear_uc();
    $display("retry test done");
    put(8'h42);
    fault = 1'b1;
    tick();
    wait_st(3'h6);
    chk(8'(n >= 39 && n <= 43), 8'h01);
    clear_uc();
    put(8'hB8);
    fault = 1'b1;
    repeat (100) tick();
    chk(8'(state == 3'h6), 8'h00);
    shdn = 1'b1;
    wait_st(3'h0);
    chk(8'(n <= 3), 8'h01);
    repeat (3) tick();
    chk(8'(state), 8'h00);
    shdn = 1'b0;
    clear_uc();
    fault = 1'b1;
    repeat (10) tick();
    en_req = 1'b0;
    wait_st(3'h0);
    chk(8'({n <= 3, oe}), 8'h02);
    en_req = 1'b1;
    clear_uc();
    $display("delay and endless retry done");
    put(8'hC0);
    fault = 1'b1;
    repeat (5) tick();
    fault = 1'b0;
    wait_st(3'h0);
    tick();
    chk(8'({n <= 3, oe}), 8'h03);
    $display("hold test done");
    clear_uc();
    ce = 1'b0;
    fault = 1'b1;
    repeat (3) tick();
    chk(8'({status, state, oe}), 8'h01);
    ce = 1'b1;
    tick();
    chk(8'({status, state, oe}), 8'h1E);
    fault = 1'b0;
    clear_uc();
    en_req = 1'b0;
    fault = 1'b1;
    repeat (2) tick();
    chk(8'({status, state, oe}), 8'h10);
    clear_uc();
    en_req = 1'b1;
    put(8'h88);
    fault = 1'b1;
    tick();
    fault = 1'b0;
    wait_st(3'h2);
    chk(8'({oe, attempts}), 8'h09);
    wait_st(3'h0);
    chk(8'({oe, attempts}), 8'h08);
    $display("enable and restart test done");
    stop_test();
  end
endmodule : tb
bind ucfr_core ucfr_core_sva chk_u (.CLK, .NRST, .CE, .CMD_CODE, .CMD_WR,
  .CMD_RD, .CMD_WDATA, .CMD_ACK, .UC_FAULT, .CLEAR_FAULTS, .OUTPUT_EN_REQ,
  .OTHER_FAULT_SHDN,
  .OUTPUT_ENABLE, .UC_STATUS, .ALERT_LINE_N, .ATTEMPT_COUNT, .SEQ_STATE);
